// ---- hw/frc_regs.sv ----
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_regs #(
    parameter int NSRC = `FRC_NUM_SRC
) (
    input  wire logic            clk,          // System clock, 40 MHz
    input  wire logic            arst_n,       // Async reset, active low
    input  wire logic            reg_wr,       // Register write strobe
    input  wire logic            reg_rd,       // Register read strobe
    input  wire logic [7:0]      reg_addr,     // Register offset
    input  wire logic [7:0]      reg_wdata,    // Write data
    output logic      [7:0]      reg_rdata,    // Read data, valid the cycle after reg_rd
    input  wire logic [NSRC-1:0] fault_raw,    // Live detector levels, asynchronous
    input  wire logic            clk_detect,   // Live clock detect status, asynchronous
    output logic      [NSRC-1:0] fault_status, // Status bits
    output logic                 clk_det_stat, // Clock detect status
    output logic                 fault_pin_n,  // Fault report pin, low on fault
    output logic                 out_hiz,      // Force class-D outputs Hi-Z
    output logic                 auto_recover, // OTSD auto recovery enable
    output logic      [1:0]      limit_level,  // Current limit level code
    output logic                 limit_on,     // Cycle limit function enable
    output logic                 limit_warn_on,// Cycle limit warning enable
    output logic                 limit_fault_on// Cycle limit fault enable
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [NSRC-1:0] raw_s1_q;
    logic [NSRC-1:0] raw_s1_d;
    logic [NSRC-1:0] raw_s2_q;
    logic [NSRC-1:0] raw_s2_d;
    logic            det_s1_q;
    logic            det_s1_d;
    logic            det_s2_q;
    logic            det_s2_d;

    // Only the second stage feeds logic; the first may still be settling
    always_comb begin
        raw_s1_d = fault_raw;
        raw_s2_d = raw_s1_q;
        det_s1_d = clk_detect;
        det_s2_d = det_s1_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_s1_q <= '0;
            raw_s2_q <= '0;
            det_s1_q <= 1'b0;
            det_s2_q <= 1'b0;
        end else begin
            raw_s1_q <= raw_s1_d;
            raw_s2_q <= raw_s2_d;
            det_s1_q <= det_s1_d;
            det_s2_q <= det_s2_d;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] rmask_q;
    logic [7:0] rmask_d;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [7:0] misc_q;
    logic [7:0] misc_d;
    logic [7:0] limit_q;
    logic [7:0] limit_d;
    logic [7:0] clr_q;
    logic [7:0] clr_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rmask_d = rmask_q;
        latch_d = latch_q;
        misc_d  = misc_q;
        limit_d = limit_q;
        clr_d   = clr_q;
        if (reg_wr) begin
            case (reg_addr)
                `FRC_ADDR_REPORT_MASK: begin
                    rmask_d = reg_wdata & `FRC_REPORT_MASK_WMASK;
                end
                `FRC_ADDR_LATCH_MASK: begin
                    latch_d = reg_wdata;
                end
                `FRC_ADDR_MISC: begin
                    misc_d = reg_wdata;
                end
                `FRC_ADDR_LIMIT: begin
                    limit_d = reg_wdata;
                end
                `FRC_ADDR_CLEAR: begin
                    clr_d = reg_wdata & `FRC_CLEAR_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets return zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                `FRC_ADDR_REPORT_MASK: rdata_d = rmask_q;
                `FRC_ADDR_LATCH_MASK:  rdata_d = latch_q;
                `FRC_ADDR_MISC:        rdata_d = misc_q;
                `FRC_ADDR_LIMIT:       rdata_d = limit_q;
                `FRC_ADDR_CLEAR:       rdata_d = clr_q;
                default:               rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rmask_q <= `FRC_RST_REPORT_MASK;
            latch_q <= `FRC_RST_LATCH_MASK;
            misc_q  <= `FRC_RST_MISC;
            limit_q <= `FRC_RST_LIMIT;
            clr_q   <= `FRC_RST_CLEAR;
            rdata_q <= 8'h00;
        end else begin
            rmask_q <= rmask_d;
            latch_q <= latch_d;
            misc_q  <= misc_d;
            limit_q <= limit_d;
            clr_q   <= clr_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Clear command sequencing
    // ****************************************
    frc_pkg::frc_wstate_t wstate_q;
    frc_pkg::frc_wstate_t wstate_d;
    logic                 aclr;

    // The clear bit is acted on, never stored: it becomes a single pulse one
    // cycle after the write, which keeps the latch update off the bus decode path
    always_comb begin
        wstate_d = frc_pkg::FRC_IDLE;
        if (reg_wr) begin
            wstate_d = frc_pkg::FRC_WRITE;
            if (reg_addr == `FRC_ADDR_CLEAR && reg_wdata[`FRC_B_ANALOG_CLEAR]) begin
                wstate_d = frc_pkg::FRC_CLEAR;
            end
        end
    end

    always_comb begin
        case (wstate_q)
            frc_pkg::FRC_CLEAR: aclr = 1'b1;
            default:            aclr = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wstate_q <= frc_pkg::FRC_IDLE;
        end else begin
            wstate_q <= wstate_d;
        end
    end

    // ****************************************
    // Status latching
    // ****************************************
    logic [NSRC-1:0] latch_en;
    logic [NSRC-1:0] stat;
    logic [NSRC-1:0] masked;
    logic            det_stat;

    always_comb begin
        // OC, DC, PVDD and DVDD faults always latch until cleared; the rest follow their latch enables
        latch_en = '1;
        latch_en[`FRC_SRC_LFAULT] = latch_q[`FRC_B_LFAULT_LATCH];
        latch_en[`FRC_SRC_LWARN]  = latch_q[`FRC_B_LWARN_LATCH];
        latch_en[`FRC_SRC_CLK]    = latch_q[`FRC_B_CLK_LATCH];
        latch_en[`FRC_SRC_OTSD]   = latch_q[`FRC_B_OTSD_LATCH];
        latch_en[`FRC_SRC_OTW]    = latch_q[`FRC_B_OTW_LATCH];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            frc_event_latch u_lat (
                .clk       (clk),
                .arst_n    (arst_n),
                .event_raw (raw_s2_q[gi]),
                .latch_on  (latch_en[gi]),
                .clear     (aclr),
                .status    (stat[gi])
            );
        end
    endgenerate

    frc_event_latch u_det (
        .clk       (clk),
        .arst_n    (arst_n),
        .event_raw (det_s2_q),
        .latch_on  (misc_q[`FRC_B_CLK_DET_HOLD]),
        .clear     (aclr),
        .status    (det_stat)
    );

    // ****************************************
    // Fault pin reporting
    // ****************************************
    // A masked fault source still latches and, unless it is LWARN or OTW, stops the output stage; only the pin ignores it
    always_comb begin
        masked = stat;
        if (rmask_q[`FRC_B_HIDE_OVERCUR])    masked[`FRC_SRC_OC]      = 1'b0;
        if (rmask_q[`FRC_B_HIDE_OFFSET])     masked[`FRC_SRC_DC]      = 1'b0;
        if (rmask_q[`FRC_B_MASK_CLK])        masked[`FRC_SRC_CLK]     = 1'b0;
        if (rmask_q[`FRC_B_HIDE_DSUP_OVER])  masked[`FRC_SRC_DVDD_OV] = 1'b0;
        if (rmask_q[`FRC_B_HIDE_DSUP_UNDER]) masked[`FRC_SRC_DVDD_UV] = 1'b0;
        if (rmask_q[`FRC_B_HIDE_OVERTEMP])   masked[`FRC_SRC_OTSD]    = 1'b0;
        if (rmask_q[`FRC_B_MASK_PVDD]) begin
            masked[`FRC_SRC_PVDD_UV] = 1'b0;
            masked[`FRC_SRC_PVDD_OV] = 1'b0;
        end
        if (latch_q[`FRC_B_HIDE_HEAT_WARN]) masked[`FRC_SRC_OTW]   = 1'b0;
        if (latch_q[`FRC_B_MASK_LWARN])   masked[`FRC_SRC_LWARN]   = 1'b0;
        if (latch_q[`FRC_B_MASK_LFAULT])  masked[`FRC_SRC_LFAULT]  = 1'b0;
    end

    // ****************************************
    // Output registers
    // ****************************************
    logic [NSRC-1:0] fstat_q;
    logic [NSRC-1:0] fstat_d;
    logic            det_q;
    logic            det_d;
    logic            pin_n_q;
    logic            pin_n_d;
    logic            hiz_q;
    logic            hiz_d;
    logic [NSRC-1:0] stop_src;

    always_comb begin
        fstat_d  = stat;
        det_d    = det_stat;
        pin_n_d  = ~(|masked);
        // Warnings do not stop the output stage; faults do
        stop_src = stat;
        stop_src[`FRC_SRC_LWARN] = 1'b0;
        stop_src[`FRC_SRC_OTW]   = 1'b0;
        // With auto recovery, OTSD releases Hi-Z once the live condition goes,
        // while its status bit stays set until software clears it
        if (misc_q[`FRC_B_AUTO_RECOVER] && !raw_s2_q[`FRC_SRC_OTSD]) begin
            stop_src[`FRC_SRC_OTSD] = 1'b0;
        end
        hiz_d = |stop_src;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fstat_q <= '0;
            det_q   <= 1'b0;
            pin_n_q <= 1'b1;
            hiz_q   <= 1'b0;
        end else begin
            fstat_q <= fstat_d;
            det_q   <= det_d;
            pin_n_q <= pin_n_d;
            hiz_q   <= hiz_d;
        end
    end

    assign reg_rdata      = rdata_q;
    assign fault_status   = fstat_q;
    assign clk_det_stat   = det_q;
    assign fault_pin_n    = pin_n_q;
    assign out_hiz        = hiz_q;

    // ****************************************
    // Configuration outputs
    // ****************************************
    // Level code 11 passes through unchanged; the analog side decides its meaning
    assign auto_recover   = misc_q[`FRC_B_AUTO_RECOVER];
    assign limit_level    = limit_q[`FRC_B_LEVEL_HI:`FRC_B_LEVEL_LO];
    assign limit_on       = limit_q[`FRC_B_LIMIT_ON];
    assign limit_warn_on  = limit_q[`FRC_B_LIMIT_WARN_ON];
    assign limit_fault_on = limit_q[`FRC_B_LIMIT_FAULT_ON];

endmodule

// ---- hw/frc_defs.svh ----
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

// Register offsets
`define FRC_ADDR_REPORT_MASK   8'h74
`define FRC_ADDR_LATCH_MASK    8'h75
`define FRC_ADDR_MISC          8'h76
`define FRC_ADDR_LIMIT         8'h77
`define FRC_ADDR_CLEAR         8'h78

// Reset values
`define FRC_RST_REPORT_MASK    8'h00
`define FRC_RST_LATCH_MASK     8'hF8
`define FRC_RST_MISC           8'h00
`define FRC_RST_LIMIT          8'h00
`define FRC_RST_CLEAR          8'h00

// Writable bits of the report mask register (bit 3 reserved, reads zero)
`define FRC_REPORT_MASK_WMASK  8'hF7

// Report mask field positions
`define FRC_B_HIDE_OVERTEMP    7
`define FRC_B_HIDE_DSUP_UNDER  6
`define FRC_B_HIDE_DSUP_OVER   5
`define FRC_B_MASK_CLK         4
`define FRC_B_MASK_PVDD        2
`define FRC_B_HIDE_OFFSET      1
`define FRC_B_HIDE_OVERCUR     0

// Latch and OTW, LWARN, LFAULT mask field positions
`define FRC_B_LFAULT_LATCH     7
`define FRC_B_LWARN_LATCH      6
`define FRC_B_CLK_LATCH        5
`define FRC_B_OTSD_LATCH       4
`define FRC_B_OTW_LATCH        3
`define FRC_B_HIDE_HEAT_WARN   2
`define FRC_B_MASK_LWARN       1
`define FRC_B_MASK_LFAULT      0

// Misc control field positions
`define FRC_B_CLK_DET_HOLD     7
`define FRC_B_AUTO_RECOVER     4

// Current limit control field positions
`define FRC_B_LEVEL_HI         4
`define FRC_B_LEVEL_LO         3
`define FRC_B_LIMIT_ON         2
`define FRC_B_LIMIT_WARN_ON    1
`define FRC_B_LIMIT_FAULT_ON   0

// Fault clear command bit
`define FRC_B_ANALOG_CLEAR     7
`define FRC_CLEAR_WMASK        8'h7F

// Fault source indices in the status vector
`define FRC_SRC_OC             0
`define FRC_SRC_DC             1
`define FRC_SRC_PVDD_UV        2
`define FRC_SRC_PVDD_OV        3
`define FRC_SRC_CLK            4
`define FRC_SRC_DVDD_OV        5
`define FRC_SRC_DVDD_UV        6
`define FRC_SRC_OTSD           7
`define FRC_SRC_LFAULT         8
`define FRC_SRC_LWARN          9
`define FRC_SRC_OTW            10
`define FRC_NUM_SRC            11

`endif

// ---- hw/frc_pkg.sv ----
package frc_pkg;

    // Current limit level as fraction of the overcurrent threshold
    typedef enum logic [1:0] {
        FRC_LVL_80 = 2'b00,
        FRC_LVL_40 = 2'b01,
        FRC_LVL_60 = 2'b10,
        FRC_LVL_RSV = 2'b11
    } frc_level_t;

    // Write sequence state of the register port
    typedef enum logic [1:0] {
        FRC_IDLE,
        FRC_WRITE,
        FRC_CLEAR
    } frc_wstate_t;

endpackage

// ---- hw/frc_event_latch.sv ----
`timescale 1ns/1ps
module frc_event_latch (
    input  wire logic clk,       // System clock
    input  wire logic arst_n,    // Async reset, active low
    input  wire logic event_raw, // Live detector level, same domain
    input  wire logic latch_on,  // 1: hold until cleared, 0: follow live
    input  wire logic clear,     // Clear pulse
    output logic      status     // Reported status
);

    logic held_q;
    logic held_d;

    always_comb begin
        held_d = held_q;
        if (clear) begin
            held_d = 1'b0;
        end
        // Set beats clear so an event in the clear cycle is kept
        if (event_raw) begin
            held_d = 1'b1;
        end
        if (!latch_on) begin
            held_d = event_raw;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= 1'b0;
        end else begin
            held_q <= held_d;
        end
    end

    assign status = held_q;

endmodule

// ---- verification/frc_regs_checker.sv ----
`timescale 1ns/1ps
module frc_regs_checker #(
    parameter int NSRC = 11
) (
    input wire logic            clk,            // Clock
    input wire logic            arst_n,         // Reset, active low
    input wire logic            reg_wr,         // Write strobe
    input wire logic            reg_rd,         // Read strobe
    input wire logic [7:0]      reg_addr,       // Offset
    input wire logic [7:0]      reg_wdata,      // Write data
    input wire logic [7:0]      reg_rdata,      // Read data
    input wire logic [NSRC-1:0] fault_raw,      // Live detectors
    input wire logic [NSRC-1:0] fault_status,   // Status bits
    input wire logic            fault_pin_n,    // Fault pin
    input wire logic            out_hiz,        // Output Hi-Z
    input wire logic            auto_recover,   // Auto recovery
    input wire logic [1:0]      limit_level,    // Limit level
    input wire logic            limit_on,       // Limit enable
    input wire logic            limit_warn_on,  // Limit warning enable
    input wire logic            limit_fault_on  // Limit fault enable
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_quiet;
        fault_raw == '0;
    endsequence
    sequence s_clear_wr;
        reg_wr && reg_addr == 8'h78 && reg_wdata[7];
    endsequence

    // Raw must stay low around the command, else set would win over clear
    property p_clear_done;
        s_quiet [*3] ##0 s_clear_wr ##1 s_quiet [*2] |=> fault_status == '0;
    endproperty
    property p_hiz_cause;
        out_hiz |-> fault_status != '0;
    endproperty
    property p_pin_cause;
        !fault_pin_n |-> fault_status != '0;
    endproperty
    property p_idle;
        fault_status == '0 |-> fault_pin_n && !out_hiz;
    endproperty
    property p_raw_set;
        $rose(fault_raw[0]) |-> ##[2:4] fault_status[0];
    endproperty
    property p_rd_clear;
        reg_rd && reg_addr == 8'h78 |=> !reg_rdata[7];
    endproperty
    property p_rd_rsv;
        reg_rd && reg_addr == 8'h74 |=> !reg_rdata[3];
    endproperty
    property p_limit_wr;
        reg_wr && reg_addr == 8'h77 |=>
            {limit_level, limit_on, limit_warn_on, limit_fault_on} == $past(reg_wdata[4:0]);
    endproperty
    property p_misc_wr;
        reg_wr && reg_addr == 8'h76 |=> auto_recover == $past(reg_wdata[4]);
    endproperty

    a_clear_done: assert property (p_clear_done) else $error("clear left status");
    a_hiz_cause: assert property (p_hiz_cause) else $error("hiz without status");
    a_pin_cause: assert property (p_pin_cause) else $error("pin without status");
    a_idle: assert property (p_idle) else $error("idle pin or hiz active");
    a_raw_set: assert property (p_raw_set) else $error("status not set");
    a_rd_clear: assert property (p_rd_clear) else $error("clear bit read one");
    a_rd_rsv: assert property (p_rd_rsv) else $error("reserved bit read one");
    a_limit_wr: assert property (p_limit_wr) else $error("limit outputs wrong");
    a_misc_wr: assert property (p_misc_wr) else $error("auto recover wrong");
endmodule

bind frc_regs frc_regs_checker #(.NSRC(NSRC)) frc_regs_checker_inst (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_raw(fault_raw),
    .fault_status(fault_status), .fault_pin_n(fault_pin_n), .out_hiz(out_hiz),
    .auto_recover(auto_recover), .limit_level(limit_level), .limit_on(limit_on),
    .limit_warn_on(limit_warn_on), .limit_fault_on(limit_fault_on));

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    // ********
    // Harness
    // ********
    logic        clk, arst_n, reg_wr, reg_rd, clk_detect, clk_det_stat, fault_pin_n;
    logic        out_hiz, auto_recover, limit_on, limit_warn_on, limit_fault_on;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [10:0] fault_raw, fault_status;
    logic [1:0]  limit_level;
    int          err_count, cmp_count, cyc;
    int          lj[5] = '{4, 7, 8, 9, 10};
    logic [7:0]  rv[5] = '{8'h00, 8'hF8, 8'h00, 8'h00, 8'h00};

    frc_regs frc_regs_inst (
        .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_raw(fault_raw),
        .clk_detect(clk_detect), .fault_status(fault_status), .clk_det_stat(clk_det_stat),
        .fault_pin_n(fault_pin_n), .out_hiz(out_hiz), .auto_recover(auto_recover),
        .limit_level(limit_level), .limit_on(limit_on), .limit_warn_on(limit_warn_on),
        .limit_fault_on(limit_fault_on));

    always #12.5 clk = ~clk;

    // Whole run is under two thousand cycles; the ceiling leaves ample slack
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (e !== g) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        idle(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        idle(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        idle(1);
        reg_rd = 1'b1;
        reg_addr = a;
        idle(1);
        reg_rd = 1'b0;
        chk("rdata", 16'(e), 16'(reg_rdata));
    endtask

    function automatic int mb(int j);
        case (j)
            2, 3: mb = 2;
            8, 9, 10: mb = j - 8;
            default: mb = j;
        endcase
    endfunction

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fault_raw = '0;
        clk_detect = 1'b0;
        idle(16);
        arst_n = 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(8'h74 + i), rv[i]);
        $display("test reset values done");
        wr(8'h74, 8'hFF);
        rd(8'h74, 8'hF7);
        wr(8'h76, 8'hFF);
        rd(8'h76, 8'hFF);
        chk("auto_recover", 1, 16'(auto_recover));
        wr(8'h76, 8'h00);
        wr(8'h78, 8'hFF);
        rd(8'h78, 8'h7F);
        wr(8'hA0, 8'h55);
        rd(8'hA0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h77, 8'((i << 3) | (i ^ 5)));
            chk("limit", 16'(((i << 3) | (i ^ 5)) & 31),
                16'({limit_level, limit_on, limit_warn_on, limit_fault_on}));
            rd(8'h77, 8'((i << 3) | (i ^ 5)));
        end
        $display("test access done");
        for (int j = 0; j < 11; j++) begin
            for (int m = 0; m < 2; m++) begin
                wr(j > 7 ? 8'h75 : 8'h74, (j > 7 ? 8'hF8 : 8'h00) | 8'(m << mb(j)));
                fault_raw[j] = 1'b1;
                idle(6);
                chk("status", 1, 16'(fault_status[j]));
                chk("pin", 16'(m), 16'(fault_pin_n));
                chk("hiz", 16'(j < 9), 16'(out_hiz));
                fault_raw[j] = 1'b0;
                idle(6);
                chk("held", 1, 16'(fault_status[j]));
                chk("hiz held", 16'(j < 9), 16'(out_hiz));
                wr(8'h78, 8'h80);
                idle(5);
                chk("cleared", 0, 16'(fault_status));
                chk("pin idle", 1, 16'(fault_pin_n));
                chk("hiz idle", 0, 16'(out_hiz));
            end
        end
        wr(8'h74, 8'h00);
        $display("test masks done");
        wr(8'h75, 8'h00);
        for (int k = 0; k < 5; k++) begin
            fault_raw[lj[k]] = 1'b1;
            idle(6);
            chk("live", 1, 16'(fault_status[lj[k]]));
            fault_raw[lj[k]] = 1'b0;
            idle(6);
            chk("follow", 0, 16'(fault_status[lj[k]]));
        end
        wr(8'h75, 8'hF8);
        $display("test latch enables done");
        wr(8'h76, 8'h10);
        fault_raw[7] = 1'b1;
        idle(6);
        chk("hiz", 1, 16'(out_hiz));
        fault_raw[7] = 1'b0;
        idle(6);
        chk("recover", 0, 16'(out_hiz));
        chk("held", 1, 16'(fault_status[7]));
        wr(8'h78, 8'h80);
        wr(8'h76, 8'h00);
        idle(5);
        chk("cleared", 0, 16'(fault_status));
        $display("test auto recovery done");
        clk_detect = 1'b1;
        idle(6);
        chk("det", 1, 16'(clk_det_stat));
        clk_detect = 1'b0;
        idle(6);
        chk("det", 0, 16'(clk_det_stat));
        wr(8'h76, 8'h80);
        clk_detect = 1'b1;
        idle(6);
        clk_detect = 1'b0;
        idle(6);
        chk("det", 1, 16'(clk_det_stat));
        wr(8'h78, 8'h80);
        idle(5);
        chk("det", 0, 16'(clk_det_stat));
        $display("test clock detect done");
        report_and_stop();
    end
endmodule
